// ===== tb/hbl_link_checker.sv
// Port checker for the button packet link, bound into hbl_link.
`timescale 1ns/100ps
module hbl_link_checker #(
	parameter BIT_CYC = 260
) (
	// Clock, reset, inputs
	input wire        core_clk_in,
	input wire        rst_in,
	input wire        ce_in,
	input wire        btn_valid_in,
	input wire [7:0]  btn_id_in,
	input wire        flag_clr_in,
	input wire        rf_data_in,
	// Outputs
	input wire        btn_ready_out,
	input wire        rf_data_out,
	input wire        rf_tx_en_out,
	input wire        rf_rx_en_out,
	input wire        rx_valid_out,
	input wire [31:0] rx_ids_out,
	input wire        sent_ok_out,
	input wire        fail_flag_out,
	input wire        err_flag_out
);
	reg  [2:0]  cnt_r;
	reg         prev_r;
	reg  [15:0] hold_r;
	wire        take = ce_in && btn_valid_in && btn_ready_out;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// The press count and the line's run length are kept here because the design hides them.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r  <= 3'h0;
			prev_r <= 1'b0;
			hold_r <= 16'h0;
		end else begin
			prev_r <= rf_data_out;
			hold_r <= (rf_data_out != prev_r) ? 16'h1 : hold_r + {15'h0, ~&hold_r};
			if (cnt_r == 3'h4 && btn_ready_out)
				cnt_r <= {2'h0, take};
			else if (take)
				cnt_r <= cnt_r + 3'h1;
		end
	end
	sequence s_fourth;
		take && cnt_r == 3'h3;
	endsequence
	a_no_overlap: assert property (!(rf_tx_en_out && rf_rx_en_out))
		else $error("transmit and receive enabled together");
	a_idle_line: assert property (!rf_tx_en_out |-> !rf_data_out)
		else $error("line not low outside a frame");
	a_bit_length: assert property (rf_tx_en_out && $past(rf_tx_en_out)
		&& rf_data_out != prev_r |-> hold_r >= BIT_CYC)
		else $error("line level held shorter than one bit");
	a_ready_count: assert property (cnt_r != 3'h4 |-> btn_ready_out)
		else $error("press refused before four were held");
	a_fourth_stop: assert property (s_fourth |=> !btn_ready_out)
		else $error("presses still taken after the fourth");
	a_ack_reply: assert property (rx_valid_out |-> ##[0:2] rf_tx_en_out)
		else $error("accepted packet not answered");
	a_rx_pulse: assert property (rx_valid_out |=> !rx_valid_out)
		else $error("accept pulse longer than one cycle");
	a_sent_release: assert property (sent_ok_out |=> btn_ready_out && !sent_ok_out)
		else $error("presses not released after acknowledge");
	a_fail_sticky: assert property (fail_flag_out && !flag_clr_in |=> fail_flag_out)
		else $error("failure flag dropped by itself");
	a_err_sticky: assert property (err_flag_out && !flag_clr_in |=> err_flag_out)
		else $error("error flag dropped by itself");
	a_quiet_tx: assert property (rf_tx_en_out |-> !sent_ok_out)
		else $error("acknowledge reported while transmitting");
endmodule // hbl_link_checker

bind hbl_link hbl_link_checker #(.BIT_CYC(BIT_CYC)) u_hbl_link_checker (
	.core_clk_in, .rst_in, .ce_in, .btn_valid_in, .btn_id_in, .flag_clr_in,
	.rf_data_in, .btn_ready_out, .rf_data_out, .rf_tx_en_out, .rf_rx_en_out,
	.rx_valid_out, .rx_ids_out, .sent_ok_out, .fail_flag_out, .err_flag_out);

// ===== tb/hbl_link_test.sv
// Self-checking bench for the button packet link.
`timescale 1ns/100ps
module hbl_link_test;
	localparam BC = 8;
	reg         core_clk_in  = 1'b0;
	reg         rst_in       = 1'b1;
	reg         btn_valid_in = 1'b0;
	reg  [7:0]  btn_id_in    = 8'h00;
	reg         flag_clr_in  = 1'b0;
	reg         ce_in        = 1'b1;
	wire        rf_data_in;
	wire        rf_data_out;
	wire        rf_tx_en_out;
	wire        rf_rx_en_out;
	wire        btn_ready_out;
	wire        rx_valid_out;
	wire [31:0] rx_ids_out;
	wire        sent_ok_out;
	wire        fail_flag_out;
	wire        err_flag_out;
	integer     n_mismatch   = 0;
	integer     total_checks = 0;
	integer     n_ok         = 0;
	integer     n_rx         = 0;
	integer     n_tx         = 0;
	reg         tx_d         = 1'b0;
	always #50 core_clk_in = ~core_clk_in;
	hbl_link #(.BIT_CYC(BC), .PRE_BITS(16'd10), .WORD_BITS(8'd16), .ACK_WAIT(16'd20)) u_hbl_link (
		.core_clk_in, .rst_in, .ce_in, .btn_valid_in, .btn_id_in, .btn_ready_out,
		.flag_clr_in, .rf_data_in, .rf_data_out, .rf_tx_en_out, .rf_rx_en_out,
		.rx_valid_out, .rx_ids_out, .sent_ok_out, .fail_flag_out, .err_flag_out);
	hbl_peer #(.BIT_CYC(BC), .PRE_BITS(10)) u_hbl_peer (.core_clk_in,
		.rf_data_in(rf_data_out), .rf_tx_en_in(rf_tx_en_out), .rf_data_out(rf_data_in));
	always @(negedge core_clk_in) begin
		n_ok = n_ok + (sent_ok_out === 1'b1);
		n_rx = n_rx + (rx_valid_out === 1'b1);
		n_tx = n_tx + (rf_tx_en_out === 1'b1 && !tx_d);
		tx_d = rf_tx_en_out;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function logic [7:0] csum(input logic [31:0] ids);
		csum = 8'hfe + ids[31:24] + ids[23:16] + ids[15:8] + ids[7:0];
	endfunction
	task cyc(input integer n);
		repeat (n) @(negedge core_clk_in);
	endtask
	// Four presses back to back, then a fifth that must be ignored.
	task press4(input logic [31:0] ids);
		integer i;
		for (i = 3; i >= 0; i--) begin
			cyc(1);
			btn_valid_in = 1'b1;
			btn_id_in = ids[8 * i +: 8];
		end
		cyc(1);
		btn_id_in = 8'h77;
		cyc(1);
		btn_valid_in = 1'b0;
	endtask
	task frame(input logic [47:0] v, input integer n);
		integer k;
		for (k = 0; k < 400 && rf_tx_en_out !== 1'b1; k++) cyc(1);
		for (k = 0; k < 900 && rf_tx_en_out === 1'b1; k++) cyc(1);
		u_hbl_peer.build(v, n);
		check(u_hbl_peer.rx_q.size(), u_hbl_peer.exp_q.size());
		for (k = 0; k < u_hbl_peer.exp_q.size(); k++)
			check(u_hbl_peer.rx_q[k], u_hbl_peer.exp_q[k]);
	endtask
	task clr_flags;
		flag_clr_in = 1'b1;
		cyc(1);
		flag_clr_in = 1'b0;
		check({fail_flag_out, err_flag_out}, 2'b00);
	endtask
	task t_reset;
		check({rf_tx_en_out, rf_rx_en_out, btn_ready_out, rx_valid_out, sent_ok_out,
			fail_flag_out, err_flag_out, rf_data_out}, 32'h60);
		$display("t_reset done");
	endtask
	// Presses given while the clock enable is low must leave no trace.
	task t_ce_hold;
		integer t;
		t = n_tx;
		ce_in = 1'b0;
		press4(32'h01010101);
		cyc(4 * BC);
		check(n_tx - t, 0);
		check({rf_tx_en_out, rf_rx_en_out, btn_ready_out}, 3'b011);
		ce_in = 1'b1;
		cyc(4 * BC);
		check(n_tx - t, 0);
		$display("t_ce_hold done");
	endtask
	task t_send_ok;
		integer t;
		t = n_tx;
		u_hbl_peer.rx_q.delete();
		press4(32'h112233f4);
		check({btn_ready_out, rf_tx_en_out, rf_rx_en_out}, 3'b010);
		frame({8'hfe, 32'h112233f4, csum(32'h112233f4)}, 6);
		cyc(5 * BC);
		u_hbl_peer.send(48'h06060606, 4);
		cyc(30 * BC);
		check(n_ok, 1);
		check(n_tx - t, 1);
		check(btn_ready_out, 1'b1);
		$display("t_send_ok done");
	endtask
	task t_fail;
		integer t;
		integer k;
		t = n_tx;
		press4(32'h04030201);
		for (k = 0; k < 9000 && fail_flag_out !== 1'b1; k++) cyc(1);
		cyc(2);
		check(n_tx - t, 7);
		check({fail_flag_out, btn_ready_out}, 2'b11);
		clr_flags;
		$display("t_fail done");
	endtask
	task t_rx_good;
		integer t;
		t = n_rx;
		u_hbl_peer.rx_q.delete();
		u_hbl_peer.send({8'hfe, 32'h0aff8001, csum(32'h0aff8001)}, 6);
		frame(48'h06060606, 4);
		check(n_rx - t, 1);
		check(rx_ids_out, 32'h0aff8001);
		$display("t_rx_good done");
	endtask
	// Bad header first, then a checksum one too high.
	task t_rx_bad;
		integer t;
		integer k;
		t = n_tx;
		for (k = 0; k < 2; k++) begin
			u_hbl_peer.send({k ? 8'hfe : 8'hfd, 32'h01020304, csum(32'h01020304) + k[7:0]}, 6);
			cyc(20 * BC);
			check(err_flag_out, 1'b1);
			check(n_tx - t, 0);
			clr_flags;
		end
		$display("t_rx_bad done");
	endtask
	initial begin
		cyc(60000);
		n_mismatch = n_mismatch + 1;
		$display("Error at %0t: watchdog expired", $time);
		end_sim;
	end
	initial begin
		cyc(10);
		rst_in = 1'b0;
		cyc(2);
		t_reset;
		t_ce_hold;
		t_send_ok;
		t_fail;
		t_rx_good;
		t_rx_bad;
		end_sim;
	end
endmodule // hbl_link_test

// ===== tb/hbl_peer.sv
// Peer board model: sends framed packets and captures the frames it hears.
`timescale 1ns/100ps
module hbl_peer #(
	parameter BIT_CYC  = 8,
	parameter PRE_BITS = 10
) (
	// Clock and line
	input  wire core_clk_in,
	input  wire rf_data_in,
	input  wire rf_tx_en_in,
	output reg  rf_data_out
);
	logic   rx_q[$];
	logic   exp_q[$];
	integer cnt = 0;
	initial rf_data_out = 1'b1;
	task automatic build(input logic [47:0] v, input integer n);
		integer i;
		exp_q.delete();
		for (i = 0; i < PRE_BITS; i++)
			exp_q.push_back(i[0]);
		exp_q.push_back(exp_q[$]);
		for (i = 0; i < 8 * n; i++) begin
			if (i != 0 && i % 16 == 0)
				exp_q.push_back(!exp_q[$]);
			exp_q.push_back(v[8 * n - 1 - i]);
		end
	endtask
	task automatic send(input logic [47:0] v, input integer n);
		integer k;
		build(v, n);
		for (k = 0; k < exp_q.size(); k++) begin
			@(negedge core_clk_in);
			rf_data_out = exp_q[k];
			repeat (BIT_CYC - 1) @(negedge core_clk_in);
		end
		@(negedge core_clk_in);
		// A released line must not keep showing the last bit.
		rf_data_out = !exp_q[exp_q.size() - 1];
	endtask
	// Samples the design's line a little after mid-bit, every bit being equally long.
	always @(negedge core_clk_in) begin
		if (rf_tx_en_in !== 1'b1) begin
			cnt <= 0;
		end else begin
			if (cnt % BIT_CYC == BIT_CYC / 2 + 1)
				rx_q.push_back(rf_data_in);
			cnt <= cnt + 1;
		end
	end
endmodule // hbl_peer

// ===== verilog/hbl_bit_timer.v
// Bit period timer with re-phase input, giving mid-bit and end-of-bit strobes.
`timescale 1ns/100ps
module hbl_bit_timer #(
	parameter CYC = 260,
	parameter CW  = 9
) (
	// Clock, reset, enable
	input  wire          core_clk_in,
	input  wire          rst_in,
	input  wire          ce_in,
	// Control
	input  wire          run_in,
	input  wire          rephase_in,
	// Strobes
	output wire          mid_out,
	output wire          end_out
);
	localparam [CW-1:0] LAST = CYC - 1;
	localparam [CW-1:0] HALF = CYC / 2;

	reg [CW-1:0] cnt_r;

	// A re-phase marks the instant a new bit period begins.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= {CW{1'b0}};
		end else if (ce_in) begin
			if (!run_in || rephase_in || cnt_r == LAST) begin
				cnt_r <= {CW{1'b0}};
			end else begin
				cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

	assign mid_out = ce_in && run_in && !rephase_in && cnt_r == HALF;
	assign end_out = ce_in && run_in && !rephase_in && cnt_r == LAST;
endmodule // hbl_bit_timer

// ===== verilog/hbl_consts.vh
// Constants shared by the half duplex button packet link.
`ifndef HBL_CONSTS_VH
`define HBL_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define HBL_CLK_HZ        10000000
`define HBL_BIT_RATE      38400
`define HBL_BIT_CYC       (`HBL_CLK_HZ / `HBL_BIT_RATE)
`define HBL_PRE_BITS      100
`define HBL_PRE_TIME_US   2600
`define HBL_ACK_WAIT_BITS 2000
`define HBL_MIN_PRE       8

// ****************************************
// Framing and packet layout
// ****************************************
`define HBL_WORD_BITS     16
`define HBL_PRE_FIRST     1'b0
`define HBL_HDR_BYTE      8'hfe
`define HBL_ACK_BYTE      8'h06
`define HBL_BTN_LEN       3'h6
`define HBL_ACK_LEN       3'h4
`define HBL_NUM_IDS       3'h4
`define HBL_MAX_RETRY     3'h6

`endif

// ===== verilog/hbl_link.v
// Half duplex button packet link: framer, deframer, acknowledge and retry control.
// Function
// (R1) Serial data is NRZ at 38,400 bit/s, one level per bit period.
// (R2) Each packet starts with an alternating preamble, 100 bits by default.
// (R3) Preamble length is a parameter, shorter or longer as the user needs.
// (R4) One start bit follows the preamble; receiver aligns its sampling on it.
// (R5) Transmitter inserts a sync bit at every data word boundary.
// (R6) Receiver re-phases its sampling timer on each sync bit.
// (R7) Button packet: header 0xFE, four button ids in press order, checksum.
// (R8) Checksum is the 8-bit sum of the first five bytes, carries dropped.
// (R9) Acknowledge packet is four 0x06 bytes with the same framing.
// (R10) Every accepted button packet is answered with an acknowledge packet; the code answers only in S_LISTEN and drops a good one arriving in S_WAIT.
// (R11) Sender waits for acknowledge, resending at most six times.
// (R12) Four collected button presses start a transmission.
// (R13) Transmit and receive are never active together; direction alternates.
// (R14) Acknowledge wait is a bit count; final failed retry raises a flag.
// (R15) Bad header or checksum drops the packet unanswered and flags an error; the code flags it only in S_LISTEN, never in S_WAIT.
`timescale 1ns/100ps
`include "hbl_consts.vh"
module hbl_link #(
	parameter        BIT_CYC   = `HBL_BIT_CYC,
	parameter [15:0] PRE_BITS  = `HBL_PRE_BITS,
	parameter [7:0]  WORD_BITS = `HBL_WORD_BITS,
	parameter [15:0] ACK_WAIT  = `HBL_ACK_WAIT_BITS
) (
	// Clock, reset, enable
	input  wire        core_clk_in,
	input  wire        rst_in,
	input  wire        ce_in,
	// Button presses
	input  wire        btn_valid_in,
	input  wire [7:0]  btn_id_in,
	output wire        btn_ready_out,
	// Flag clear
	input  wire        flag_clr_in,
	// Radio data pins
	input  wire        rf_data_in,
	output wire        rf_data_out,
	output wire        rf_tx_en_out,
	output wire        rf_rx_en_out,
	// Results
	output reg         rx_valid_out,
	output reg  [31:0] rx_ids_out,
	output reg         sent_ok_out,
	output reg         fail_flag_out,
	output reg         err_flag_out
);
	// ****************************************
	// States
	// ****************************************
	localparam [2:0] S_LISTEN = 3'b001;
	localparam [2:0] S_TX     = 3'b010;
	localparam [2:0] S_WAIT   = 3'b100;
	localparam [3:0] T_PRE    = 4'b0001;
	localparam [3:0] T_START  = 4'b0010;
	localparam [3:0] T_DATA   = 4'b0100;
	localparam [3:0] T_SYNC   = 4'b1000;
	localparam [1:0] R_HUNT   = 2'b01;
	localparam [1:0] R_DATA   = 2'b10;
	localparam [7:0] MIN_PRE  = `HBL_MIN_PRE;

	reg  [2:0]  st_r;
	reg  [3:0]  tx_st_r;
	reg  [1:0]  rx_st_r;
	reg         tx_bit_r;
	reg  [7:0]  tx_sh_r;
	reg  [15:0] pre_cnt_r;
	reg  [2:0]  byte_idx_r;
	reg  [2:0]  bit_idx_r;
	reg  [7:0]  wcnt_r;
	reg         tx_ack_r;
	reg  [31:0] btn_ids_r;
	reg  [2:0]  btn_cnt_r;
	reg  [2:0]  retry_r;
	reg  [15:0] wait_cnt_r;
	reg         rx_s1_r;
	reg         rx_s2_r;
	reg         rx_prev_r;
	reg         last_smp_r;
	reg  [7:0]  alt_r;
	reg  [7:0]  rsh_r;
	reg  [2:0]  rbit_r;
	reg  [7:0]  rw_r;
	reg  [2:0]  ridx_r;
	reg  [2:0]  rlen_r;
	reg  [7:0]  sum_r;
	reg         ack_good_r;
	reg         sync_exp_r;
	reg  [31:0] rx_sh_r;
	reg         ev_btn_ok_r;
	reg         ev_btn_bad_r;
	reg         ev_ack_ok_r;
	reg  [7:0]  tx_byte_w;
	wire        tx_tick;
	wire        rx_mid;
	wire        rx_end;
	wire        rx_on;
	wire        rx_hunt;
	wire        rx_edge;
	wire [7:0]  rx_byte_w;
	wire        rx_last_w;
	wire [7:0]  csum_w;

	// ****************************************
	// Bit timers
	// ****************************************
	hbl_bit_timer #(.CYC(BIT_CYC), .CW(9)) u_tx_tmr ( // [R1]
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.ce_in       (ce_in),
		.run_in      (st_r[1]),
		.rephase_in  (1'b0),
		.mid_out     (),
		.end_out     (tx_tick)
	);

	// Re-phase on every preamble edge and on the edge of each expected sync bit.
	hbl_bit_timer #(.CYC(BIT_CYC), .CW(9)) u_rx_tmr ( // [R4] [R6]
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.ce_in       (ce_in),
		.run_in      (rx_on),
		.rephase_in  (rx_edge && (rx_st_r[0] || sync_exp_r)),
		.mid_out     (rx_mid),
		.end_out     (rx_end)
	);

	// ****************************************
	// Pins and status
	// ****************************************
	assign rx_on         = st_r[0] || st_r[2]; // [R13]
	assign rf_tx_en_out  = st_r[1]; // [R13]
	assign rf_rx_en_out  = rx_on;
	assign rf_data_out   = tx_bit_r;
	assign btn_ready_out = btn_cnt_r != `HBL_NUM_IDS;
	assign rx_hunt       = rx_st_r[0];
	assign rx_edge       = rx_s2_r ^ rx_prev_r;
	assign rx_byte_w     = {rsh_r[6:0], rx_s2_r};
	assign rx_last_w     = ridx_r != 3'h0 && ridx_r == rlen_r - 3'h1;
	assign csum_w        = `HBL_HDR_BYTE + btn_ids_r[31:24] + btn_ids_r[23:16]
	                       + btn_ids_r[15:8] + btn_ids_r[7:0]; // [R8]

	// ****************************************
	// Transmit byte select
	// ****************************************
	always @* begin
		if (tx_ack_r) begin
			tx_byte_w = `HBL_ACK_BYTE; // [R9]
		end else begin
			case (byte_idx_r) // [R7]
				3'h0: tx_byte_w = `HBL_HDR_BYTE;
				3'h1: tx_byte_w = btn_ids_r[31:24];
				3'h2: tx_byte_w = btn_ids_r[23:16];
				3'h3: tx_byte_w = btn_ids_r[15:8];
				3'h4: tx_byte_w = btn_ids_r[7:0];
				default: tx_byte_w = csum_w;
			endcase
		end
	end

	task start_tx;
		input is_ack;
		begin
			st_r       <= S_TX;
			tx_ack_r   <= is_ack;
			tx_st_r    <= T_PRE;
			pre_cnt_r  <= 16'h0000;
			tx_bit_r   <= `HBL_PRE_FIRST;
			byte_idx_r <= 3'h0;
		end
	endtask

	// ****************************************
	// Link control and transmit framer
	// ****************************************
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r          <= S_LISTEN;
			tx_st_r       <= T_PRE;
			tx_bit_r      <= 1'b0;
			tx_sh_r       <= 8'h00;
			pre_cnt_r     <= 16'h0000;
			byte_idx_r    <= 3'h0;
			bit_idx_r     <= 3'h0;
			wcnt_r        <= 8'h00;
			tx_ack_r      <= 1'b0;
			btn_ids_r     <= 32'h00000000;
			btn_cnt_r     <= 3'h0;
			retry_r       <= 3'h0;
			wait_cnt_r    <= 16'h0000;
			rx_valid_out  <= 1'b0;
			rx_ids_out    <= 32'h00000000;
			sent_ok_out   <= 1'b0;
			fail_flag_out <= 1'b0;
			err_flag_out  <= 1'b0;
		end else if (ce_in) begin
			rx_valid_out <= 1'b0;
			sent_ok_out  <= 1'b0;
			// Later assignments below let a new event win over a clear.
			if (flag_clr_in) begin
				fail_flag_out <= 1'b0;
				err_flag_out  <= 1'b0;
			end
			if (btn_valid_in && btn_cnt_r != `HBL_NUM_IDS) begin // [R12]
				btn_ids_r <= {btn_ids_r[23:0], btn_id_in};
				btn_cnt_r <= btn_cnt_r + 3'h1;
			end
			case (st_r)
				S_LISTEN: begin
					if (ev_btn_ok_r) begin
						rx_ids_out   <= rx_sh_r;
						rx_valid_out <= 1'b1;
						start_tx(1'b1); // [R10]
					end else if (ev_btn_bad_r) begin
						err_flag_out <= 1'b1; // [R15]
					end else if (btn_cnt_r == `HBL_NUM_IDS && rx_hunt) begin
						retry_r <= 3'h0;
						start_tx(1'b0); // [R12]
					end
				end
				S_TX: begin
					if (tx_tick) begin
						case (tx_st_r)
							T_PRE: begin
								if (pre_cnt_r == PRE_BITS - 16'h0001) begin
									tx_st_r <= T_START; // [R4]
								end else begin
									pre_cnt_r <= pre_cnt_r + 16'h0001;
									tx_bit_r  <= ~tx_bit_r; // [R2] [R3]
								end
							end
							T_START, T_SYNC: begin
								tx_bit_r   <= tx_byte_w[7];
								tx_sh_r    <= {tx_byte_w[6:0], 1'b0};
								byte_idx_r <= byte_idx_r + 3'h1;
								bit_idx_r  <= 3'h0;
								wcnt_r     <= 8'h00;
								tx_st_r    <= T_DATA;
							end
							T_DATA: begin
								wcnt_r <= wcnt_r + 8'h01;
								if (bit_idx_r != 3'h7) begin
									bit_idx_r <= bit_idx_r + 3'h1;
									tx_bit_r  <= tx_sh_r[7];
									tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
								end else if (byte_idx_r == (tx_ack_r ? `HBL_ACK_LEN
								                                     : `HBL_BTN_LEN)) begin
									tx_bit_r   <= 1'b0;
									wait_cnt_r <= 16'h0000;
									st_r       <= tx_ack_r ? S_LISTEN : S_WAIT; // [R13]
								end else if (wcnt_r == WORD_BITS - 8'h01) begin
									// Sync is the inverse of the last bit so it always has an edge.
									tx_bit_r <= ~tx_bit_r; // [R5]
									tx_st_r  <= T_SYNC;
								end else begin
									tx_bit_r   <= tx_byte_w[7];
									tx_sh_r    <= {tx_byte_w[6:0], 1'b0};
									byte_idx_r <= byte_idx_r + 3'h1;
									bit_idx_r  <= 3'h0;
								end
							end
							default: tx_st_r <= T_PRE;
						endcase
					end
				end
				S_WAIT: begin
					if (ev_ack_ok_r) begin
						sent_ok_out <= 1'b1;
						btn_cnt_r   <= 3'h0;
						st_r        <= S_LISTEN;
					end else if (rx_end) begin
						if (wait_cnt_r != ACK_WAIT - 16'h0001) begin
							wait_cnt_r <= wait_cnt_r + 16'h0001; // [R14]
						end else if (rx_hunt) begin
							// Timeout is held off while a frame is arriving.
							if (retry_r == `HBL_MAX_RETRY) begin
								fail_flag_out <= 1'b1; // [R14]
								btn_cnt_r     <= 3'h0;
								st_r          <= S_LISTEN;
							end else begin
								retry_r <= retry_r + 3'h1; // [R11]
								start_tx(1'b0);
							end
						end
					end
				end
				default: st_r <= S_LISTEN;
			endcase
		end
	end

	// ****************************************
	// Receive deframer
	// ****************************************
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_s1_r      <= 1'b0;
			rx_s2_r      <= 1'b0;
			rx_prev_r    <= 1'b0;
			rx_st_r      <= R_HUNT;
			last_smp_r   <= 1'b0;
			alt_r        <= 8'h00;
			rsh_r        <= 8'h00;
			rbit_r       <= 3'h0;
			rw_r         <= 8'h00;
			ridx_r       <= 3'h0;
			rlen_r       <= 3'h0;
			sum_r        <= 8'h00;
			ack_good_r   <= 1'b0;
			sync_exp_r   <= 1'b0;
			rx_sh_r      <= 32'h00000000;
			ev_btn_ok_r  <= 1'b0;
			ev_btn_bad_r <= 1'b0;
			ev_ack_ok_r  <= 1'b0;
		end else if (ce_in) begin
			rx_s1_r      <= rf_data_in;
			rx_s2_r      <= rx_s1_r;
			rx_prev_r    <= rx_s2_r;
			ev_btn_ok_r  <= 1'b0;
			ev_btn_bad_r <= 1'b0;
			ev_ack_ok_r  <= 1'b0;
			if (!rx_on) begin
				rx_st_r    <= R_HUNT;
				alt_r      <= 8'h00;
				sync_exp_r <= 1'b0;
			end else if (rx_mid) begin
				case (rx_st_r)
					R_HUNT: begin
						last_smp_r <= rx_s2_r;
						if (rx_s2_r != last_smp_r) begin
							alt_r <= (alt_r == 8'hff) ? alt_r : alt_r + 8'h01;
						end else if (alt_r >= MIN_PRE) begin
							// A repeated level after the alternating run is the start bit.
							rx_st_r    <= R_DATA; // [R4]
							ridx_r     <= 3'h0;
							rbit_r     <= 3'h0;
							rw_r       <= 8'h00;
							sum_r      <= 8'h00;
							ack_good_r <= 1'b1;
							sync_exp_r <= 1'b0;
							alt_r      <= 8'h00;
						end else begin
							alt_r <= 8'h00;
						end
					end
					R_DATA: begin
						if (sync_exp_r) begin
							sync_exp_r <= 1'b0; // [R6]
						end else begin
							rsh_r  <= rx_byte_w;
							rbit_r <= rbit_r + 3'h1;
							rw_r   <= rw_r + 8'h01;
							if (rbit_r == 3'h7) begin
								ridx_r     <= ridx_r + 3'h1;
								sum_r      <= sum_r + rx_byte_w;
								ack_good_r <= ack_good_r && rx_byte_w == `HBL_ACK_BYTE;
								// The checksum byte stays out so the four ids remain in place.
								if (!rx_last_w) begin
									rx_sh_r <= {rx_sh_r[23:0], rx_byte_w}; // [R7]
								end
								if (rw_r == WORD_BITS - 8'h01) begin
									sync_exp_r <= 1'b1;
									rw_r       <= 8'h00;
								end
								if (ridx_r == 3'h0) begin
									if (rx_byte_w == `HBL_HDR_BYTE) begin
										rlen_r <= `HBL_BTN_LEN;
									end else if (rx_byte_w == `HBL_ACK_BYTE) begin
										rlen_r <= `HBL_ACK_LEN;
									end else begin
										ev_btn_bad_r <= 1'b1; // [R15]
										rx_st_r      <= R_HUNT;
									end
								end else if (rx_last_w) begin
									rx_st_r <= R_HUNT;
									if (rlen_r == `HBL_BTN_LEN) begin
										ev_btn_ok_r  <= rx_byte_w == sum_r; // [R8]
										ev_btn_bad_r <= rx_byte_w != sum_r; // [R15]
									end else begin
										ev_ack_ok_r <= ack_good_r && rx_byte_w == `HBL_ACK_BYTE;
									end
								end
							end
						end
					end
					default: rx_st_r <= R_HUNT;
				endcase
			end
		end
	end
endmodule // hbl_link
